//--- core/sfr_fault_response.sv
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
// Notes on behaviour
// - Either regulator low holds the device in reset for as long as it lasts.
// - No bus command is answered or accepted during any reset-causing fault.
// - Downstream switch opens within switch-open time of any reset-causing fault.
// - Short reserve dip, self-check off: flags 0/0/1, short zero, long normal.
// - Short reserve dip, self-check on: flags 0/1/1, both replies carry data.
// - Reserve recovering before its reset period keeps configuration intact.
// - Long reserve low resets every reserve period until recovery or supply low.
// - Capacitor test failure resets every cap period until the failure clears.
// - Bus low beyond frame timeout resets every timeout until recovery or supply low.
// - Factory CRC fault with lock, self-check off: flags 1/0/0, short zero.
// - Two consecutive disables lock out self-check until listed clearing events.
// - Under lockout an enable does nothing and self-check flag reads cleared.
// - Internal-fault flag is 1 exactly while an internal error is detected.
module sfr_fault_response
  import sfr_pkg::*;
#(
  parameter int RESERVE_LOW_RESET_PERIOD_US = sfr_pkg::RESERVE_LOW_RESET_US,
  parameter int CAP_FAULT_RESET_PERIOD_US   = sfr_pkg::CAP_FAULT_RESET_US,
  parameter int FRAME_TIMEOUT_TIME_US       = sfr_pkg::FRAME_TIMEOUT_US,
  parameter int CNT_W                       = sfr_pkg::TIMER_W,
  parameter int DATA_W                      = sfr_pkg::ACCEL_W
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              digital_regulator_low,
  input  wire logic              analog_regulator_low,
  input  wire logic              reserve_cap_low,
  input  wire logic              upstream_bus_low,
  input  wire logic              cap_test_fail,
  input  wire logic              otp_crc_fail,
  input  wire logic              otp_lock_factory,
  input  wire logic [DATA_W-1:0] accel_sample,
  output logic                   device_reset,
  output logic                   respond_enable,
  output logic                   downstream_switch_closed,
  output logic                   internal_fault_flag,
  output logic                   self_check_on_flag,
  output logic                   reserve_low_flag,
  output logic [DATA_W-1:0]      short_accel_data,
  output logic [DATA_W-1:0]      long_accel_data
);

  import sfr_pkg::*;

  localparam logic [CNT_W-1:0] RESERVE_CYC =
    CNT_W'(sfr_us_to_cycles(RESERVE_LOW_RESET_PERIOD_US));
  localparam logic [CNT_W-1:0] CAP_CYC =
    CNT_W'(sfr_us_to_cycles(CAP_FAULT_RESET_PERIOD_US));
  localparam logic [CNT_W-1:0] FRAME_CYC =
    CNT_W'(sfr_us_to_cycles(FRAME_TIMEOUT_TIME_US));

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic        regulator_low;
  logic        reserve_fire;
  logic        cap_fire;
  logic        frame_fire;
  logic        reserve_long_reg;
  logic        frame_long_reg;
  logic        cap_fail_d_reg;
  logic        cap_onset;
  logic        reset_pulse;
  logic        fault_active;
  logic        self_check_reg;
  logic        lockout_reg;
  logic        last_disable_reg;
  logic        configured_reg;
  logic [15:0] reset_count_reg;
  logic        fault_now;
  logic        short_zero;
  logic        dp_write_reg;
  logic [7:0]  dp_addr_reg;
  logic        ap_take;
  logic        cmd_valid;
  logic        cmd_st_enable;
  logic        cmd_st_disable;
  logic        cmd_clear;
  logic        cmd_init_done;
  logic        cmd_sw_close;
  logic        lock_clear;
  logic [31:0] status_word;

  // ---------------------------------------------------------------
  // Fault detection
  // ---------------------------------------------------------------
  assign regulator_low = digital_regulator_low | analog_regulator_low;
  assign cap_onset     = cap_test_fail & ~cap_fail_d_reg;
  assign reset_pulse   = reserve_fire | cap_fire | frame_fire | cap_onset;
  assign fault_active  = regulator_low | reserve_long_reg | frame_long_reg |
                         cap_test_fail | reset_pulse;
  assign fault_now     = otp_crc_fail & otp_lock_factory;

  // Supply low takes over: the periodic timers stop while it lasts
  sfr_period_timer #(
    .CNT_W (CNT_W)
  ) u_reserve_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .active  (reserve_cap_low & ~regulator_low),
    .period  (RESERVE_CYC),
    .fire    (reserve_fire)
  );

  sfr_period_timer #(
    .CNT_W (CNT_W)
  ) u_cap_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .active  (cap_test_fail & ~regulator_low),
    .period  (CAP_CYC),
    .fire    (cap_fire)
  );

  sfr_period_timer #(
    .CNT_W (CNT_W)
  ) u_frame_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .active  (upstream_bus_low & ~regulator_low),
    .period  (FRAME_CYC),
    .fire    (frame_fire)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reserve_long_reg <= 1'b0;
    end else if (clk_en) begin
      if (!reserve_cap_low || regulator_low) begin
        reserve_long_reg <= 1'b0;
      end else if (reserve_fire) begin
        reserve_long_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_long_reg <= 1'b0;
    end else if (clk_en) begin
      if (!upstream_bus_low || regulator_low) begin
        frame_long_reg <= 1'b0;
      end else if (frame_fire) begin
        frame_long_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_fail_d_reg <= 1'b0;
    end else if (clk_en) begin
      cap_fail_d_reg <= cap_test_fail;
    end
  end

  // ---------------------------------------------------------------
  // Reset, response and switch outputs
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      device_reset <= 1'b1;
    end else if (clk_en) begin
      device_reset <= regulator_low | reset_pulse;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      respond_enable <= 1'b0;
    end else if (clk_en) begin
      respond_enable <= ~fault_active;
    end
  end

  // One cycle from fault to open, well inside the switch-open time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      downstream_switch_closed <= 1'b0;
    end else if (clk_en) begin
      if (fault_active || cmd_clear) begin
        downstream_switch_closed <= 1'b0;
      end else if (cmd_sw_close) begin
        downstream_switch_closed <= 1'b1;
      end
    end
  end

  // Cleared by real resets and the clear command; a short reserve dip leaves it alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      configured_reg <= 1'b0;
    end else if (clk_en) begin
      if (regulator_low || reset_pulse || cmd_clear) begin
        configured_reg <= 1'b0;
      end else if (cmd_init_done) begin
        configured_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_count_reg <= COUNT_RESET;
    end else if (clk_en) begin
      if (reset_pulse && reset_count_reg != 16'hFFFF) begin
        reset_count_reg <= reset_count_reg + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Self-check and lockout
  // ---------------------------------------------------------------
  // Cap-test resets do not release the lockout, frame and supply ones do
  assign lock_clear = reserve_cap_low | cmd_clear | regulator_low | frame_fire;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_disable_reg <= 1'b0;
    end else if (clk_en) begin
      if (regulator_low || reset_pulse || cmd_clear || cmd_st_enable) begin
        last_disable_reg <= 1'b0;
      end else if (cmd_st_disable) begin
        last_disable_reg <= 1'b1;
      end
    end
  end

  // Second disable wins over a clearing event in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lockout_reg <= 1'b0;
    end else if (clk_en) begin
      if (cmd_st_disable && last_disable_reg) begin
        lockout_reg <= 1'b1;
      end else if (lock_clear) begin
        lockout_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      self_check_reg <= 1'b0;
    end else if (clk_en) begin
      if (regulator_low || reset_pulse || cmd_clear || cmd_st_disable) begin
        self_check_reg <= 1'b0;
      end else if (cmd_st_enable && !lockout_reg) begin
        self_check_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Response flags and acceleration data
  // ---------------------------------------------------------------
  assign short_zero = fault_now | (reserve_cap_low & ~self_check_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_fault_flag <= 1'b0;
      self_check_on_flag  <= 1'b0;
      reserve_low_flag    <= 1'b0;
    end else if (clk_en) begin
      internal_fault_flag <= fault_now;
      self_check_on_flag  <= self_check_reg;
      reserve_low_flag    <= reserve_cap_low;
    end
  end

  // Self-check deflection already rides on the sample while active
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_accel_data <= '0;
      long_accel_data  <= '0;
    end else if (clk_en) begin
      short_accel_data <= short_zero ? '0 : accel_sample;
      long_accel_data  <= accel_sample;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  assign ap_take = hsel & hready & (htrans == HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else if (clk_en) begin
      dp_write_reg <= ap_take & hwrite;
      dp_addr_reg  <= haddr[7:0];
    end
  end

  // Commands are dropped while the device is not answering
  assign cmd_valid      = dp_write_reg & (dp_addr_reg == ADDR_COMMAND) & ~fault_active;
  assign cmd_st_enable  = cmd_valid & hwdata[CMD_ST_ENABLE_BIT];
  assign cmd_st_disable = cmd_valid & hwdata[CMD_ST_DISABLE_BIT];
  assign cmd_clear      = cmd_valid & hwdata[CMD_CLEAR_BIT];
  assign cmd_init_done  = cmd_valid & hwdata[CMD_INIT_DONE_BIT];
  assign cmd_sw_close   = cmd_valid & hwdata[CMD_SW_CLOSE_BIT];

  always_comb begin
    status_word                   = 32'h0000_0000;
    status_word[ST_FAULT_BIT]     = internal_fault_flag;
    status_word[ST_SELFCHK_BIT]   = self_check_on_flag;
    status_word[ST_RESLOW_BIT]    = reserve_low_flag;
    status_word[ST_LOCKOUT_BIT]   = lockout_reg;
    status_word[ST_RESET_BIT]     = device_reset;
    status_word[ST_SWITCH_BIT]    = downstream_switch_closed;
    status_word[ST_RESPOND_BIT]   = respond_enable;
    status_word[ST_CONFIG_BIT]    = configured_reg;
    status_word[ST_CAUSE_REG_BIT] = regulator_low;
    status_word[ST_CAUSE_RES_BIT] = reserve_long_reg;
    status_word[ST_CAUSE_CAP_BIT] = cap_test_fail;
    status_word[ST_CAUSE_FRM_BIT] = frame_long_reg;
  end

  // Read data captured at the address phase edge, stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= RDATA_RESET;
    end else if (clk_en) begin
      if (ap_take && !hwrite) begin
        unique case (haddr[7:0])
          ADDR_STATUS:      hrdata <= status_word;
          ADDR_RESET_COUNT: hrdata <= {16'h0000, reset_count_reg};
          default:          hrdata <= RDATA_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

endmodule : sfr_fault_response

//--- core/sfr_period_timer.sv
`timescale 1ns/100ps
module sfr_period_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  input  wire logic             active,
  input  wire logic [CNT_W-1:0] period,
  output logic                  fire
);

  logic [CNT_W-1:0] cnt_reg;

  // ---------------------------------------------------------------
  // Restarting period counter
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      fire    <= 1'b0;
    end else if (clk_en) begin
      if (!active) begin
        cnt_reg <= '0;
        fire    <= 1'b0;
      end else if (cnt_reg == period - CNT_W'(1)) begin
        cnt_reg <= '0;
        fire    <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + CNT_W'(1);
        fire    <= 1'b0;
      end
    end
  end

endmodule : sfr_period_timer

//--- core/sfr_pkg.sv
package sfr_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ              = 10;
  localparam int FRAME_TIMEOUT_US     = 1000;
  localparam int RESERVE_LOW_RESET_US = 2000;
  localparam int CAP_FAULT_RESET_US   = 4000;
  localparam int SWITCH_OPEN_US       = 10;
  localparam int SWITCH_OPEN_CYC      = SWITCH_OPEN_US * CLK_MHZ;
  localparam int TIMER_W              = 16;
  localparam int ACCEL_W              = 16;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS      = 8'h00;
  localparam logic [7:0] ADDR_COMMAND     = 8'h04;
  localparam logic [7:0] ADDR_RESET_COUNT = 8'h08;

  // Status fields
  localparam int ST_FAULT_BIT     = 0;
  localparam int ST_SELFCHK_BIT   = 1;
  localparam int ST_RESLOW_BIT    = 2;
  localparam int ST_LOCKOUT_BIT   = 3;
  localparam int ST_RESET_BIT     = 4;
  localparam int ST_SWITCH_BIT    = 5;
  localparam int ST_RESPOND_BIT   = 6;
  localparam int ST_CONFIG_BIT    = 7;
  localparam int ST_CAUSE_REG_BIT = 8;
  localparam int ST_CAUSE_RES_BIT = 9;
  localparam int ST_CAUSE_CAP_BIT = 10;
  localparam int ST_CAUSE_FRM_BIT = 11;

  // Command fields (write-one pulses)
  localparam int CMD_ST_ENABLE_BIT  = 0;
  localparam int CMD_ST_DISABLE_BIT = 1;
  localparam int CMD_CLEAR_BIT      = 2;
  localparam int CMD_INIT_DONE_BIT  = 3;
  localparam int CMD_SW_CLOSE_BIT   = 4;

  // Reset values
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  function automatic int sfr_us_to_cycles(input int us);
    int c;
    c = us * CLK_MHZ;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction : sfr_us_to_cycles

endpackage : sfr_pkg

//--- dv/sfr_dsi_master_model.sv
`timescale 1ns/100ps
module sfr_dsi_master_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        stuck_go,
  input  wire logic [15:0] stuck_len,
  output logic             upstream_bus_low
);
  logic [15:0] low_cnt;
  logic [4:0]  slot;
  // Frame dips of 3 cycles every 32 keep the frame timer busy but short
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) slot <= 5'h00;
    else slot <= slot + 5'h01;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_cnt <= 16'h0000;
    else if (stuck_go) low_cnt <= stuck_len;
    else if (low_cnt != 16'h0000) low_cnt <= low_cnt - 16'h0001;
  end
  assign upstream_bus_low = (low_cnt != 16'h0000) || (slot < 5'h03);
endmodule : sfr_dsi_master_model

//--- dv/sfr_fault_response_sva.sv
`timescale 1ns/100ps
module sfr_fault_response_sva #(
  parameter int RESERVE_LOW_RESET_PERIOD_US = 2000,
  parameter int CAP_FAULT_RESET_PERIOD_US   = 4000,
  parameter int FRAME_TIMEOUT_TIME_US       = 1000,
  parameter int DATA_W                      = 16
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              digital_regulator_low,
  input wire logic              analog_regulator_low,
  input wire logic              reserve_cap_low,
  input wire logic              upstream_bus_low,
  input wire logic              cap_test_fail,
  input wire logic              otp_crc_fail,
  input wire logic              otp_lock_factory,
  input wire logic [DATA_W-1:0] accel_sample,
  input wire logic              device_reset,
  input wire logic              respond_enable,
  input wire logic              downstream_switch_closed,
  input wire logic              internal_fault_flag,
  input wire logic              reserve_low_flag,
  input wire logic [DATA_W-1:0] short_accel_data,
  input wire logic [DATA_W-1:0] long_accel_data
);
  localparam int RES_N = RESERVE_LOW_RESET_PERIOD_US * 10;
  localparam int CAP_N = CAP_FAULT_RESET_PERIOD_US * 10;
  localparam int FRM_N = FRAME_TIMEOUT_TIME_US * 10;
  localparam int SW_N  = 100;
  logic [15:0] res_cnt;
  logic [15:0] bus_cnt;
  logic        reg_low;
  logic        s_cond;
  assign reg_low = digital_regulator_low | analog_regulator_low;
  assign s_cond  = otp_crc_fail & otp_lock_factory;
  // Run lengths of reserve low and bus low, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) res_cnt <= 16'h0000;
    else if (!reserve_cap_low) res_cnt <= 16'h0000;
    else if (res_cnt != 16'hFFFF) res_cnt <= res_cnt + 16'h0001;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) bus_cnt <= 16'h0000;
    else if (!upstream_bus_low) bus_cnt <= 16'h0000;
    else if (bus_cnt != 16'hFFFF) bus_cnt <= bus_cnt + 16'h0001;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_res_pulse;
    $rose(device_reset) && !reg_low && !cap_test_fail && res_cnt >= RES_N;
  endsequence
  sequence s_frm_pulse;
    $rose(device_reset) && !reg_low && !cap_test_fail && bus_cnt >= FRM_N;
  endsequence
  sequence s_cap_pulse;
    device_reset && cap_test_fail && !reg_low && !reserve_cap_low;
  endsequence
  a_reg_hold: assert property (reg_low |=> device_reset && !respond_enable)
    else $error("reset not held under regulator low");
  a_cap_onset: assert property ($rose(cap_test_fail) && !reg_low |=> device_reset && !respond_enable)
    else $error("no reset on capacitor fault");
  a_switch_open: assert property ($rose(device_reset) |-> ##[0:SW_N] !downstream_switch_closed)
    else $error("switch not opened in time");
  a_res_repeat: assert property (s_res_pulse |-> ##RES_N (device_reset || res_cnt < RES_N))
    else $error("reserve low reset not repeated");
  a_frm_repeat: assert property (s_frm_pulse |-> ##FRM_N (device_reset || bus_cnt < FRM_N))
    else $error("frame timeout reset not repeated");
  a_cap_repeat: assert property (s_cap_pulse |-> ##CAP_N (device_reset || !cap_test_fail))
    else $error("capacitor reset not repeated");
  a_fault_flag: assert property ($past(hresetn) |-> internal_fault_flag == $past(s_cond))
    else $error("internal fault flag wrong");
  a_reslow_flag: assert property ($past(hresetn) |-> reserve_low_flag == $past(reserve_cap_low))
    else $error("reserve low flag wrong");
  a_short_zero: assert property ($past(hresetn) && $past(s_cond) |-> short_accel_data == '0)
    else $error("short data not zero under fault");
  a_short_pass: assert property ($past(hresetn) && !$past(s_cond) && !$past(reserve_cap_low)
      |-> short_accel_data == $past(accel_sample))
    else $error("short data altered without fault");
  a_long_pass: assert property ($past(hresetn) |-> long_accel_data == $past(accel_sample))
    else $error("long data altered");
endmodule : sfr_fault_response_sva

bind sfr_fault_response sfr_fault_response_sva #(
  .RESERVE_LOW_RESET_PERIOD_US(RESERVE_LOW_RESET_PERIOD_US),
  .CAP_FAULT_RESET_PERIOD_US(CAP_FAULT_RESET_PERIOD_US),
  .FRAME_TIMEOUT_TIME_US(FRAME_TIMEOUT_TIME_US),
  .DATA_W(DATA_W)
) i_sva (.hclk, .hresetn, .digital_regulator_low, .analog_regulator_low, .reserve_cap_low,
  .upstream_bus_low, .cap_test_fail, .otp_crc_fail, .otp_lock_factory, .accel_sample,
  .device_reset, .respond_enable, .downstream_switch_closed, .internal_fault_flag,
  .reserve_low_flag, .short_accel_data, .long_accel_data);

//--- dv/tb_sfr_fault_response.sv
`timescale 1ns/100ps
module tb_sfr_fault_response;
  import sfr_pkg::*;
  localparam int RES_N = 50;
  localparam int CAP_N = 40;
  localparam int FRM_N = 30;
  typedef struct packed {
    logic        crc;
    logic        lock;
    logic        res;
    logic [15:0] acc;
    logic        s;
    logic        u;
    logic [15:0] sh;
  } sfr_row_t;
  logic        hclk, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, c0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, digital_regulator_low = 1'b0, analog_regulator_low = 1'b0;
  logic        reserve_cap_low = 1'b0, upstream_bus_low, cap_test_fail = 1'b0;
  logic        otp_crc_fail = 1'b0, otp_lock_factory = 1'b0, stuck_go = 1'b0;
  logic [15:0] accel_sample = 16'h0, stuck_len = 16'h0, short_accel_data, long_accel_data;
  logic        device_reset, respond_enable, downstream_switch_closed;
  logic        internal_fault_flag, self_check_on_flag, reserve_low_flag;
  int          num_errors = 0, n_tests = 0;
  sfr_row_t    rows [6] = '{
    '{1'b0, 1'b0, 1'b0, 16'h1234, 1'b0, 1'b0, 16'h1234},
    '{1'b1, 1'b1, 1'b0, 16'h5A5A, 1'b1, 1'b0, 16'h0000},
    '{1'b1, 1'b0, 1'b0, 16'hA5C3, 1'b0, 1'b0, 16'hA5C3},
    '{1'b0, 1'b1, 1'b0, 16'h0F0F, 1'b0, 1'b0, 16'h0F0F},
    '{1'b0, 1'b0, 1'b1, 16'hFFFF, 1'b0, 1'b1, 16'h0000},
    '{1'b1, 1'b1, 1'b1, 16'h8001, 1'b1, 1'b1, 16'h0000}};
  sfr_fault_response #(.RESERVE_LOW_RESET_PERIOD_US(5), .CAP_FAULT_RESET_PERIOD_US(4),
    .FRAME_TIMEOUT_TIME_US(3)) i_dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .digital_regulator_low, .analog_regulator_low, .reserve_cap_low, .upstream_bus_low,
    .cap_test_fail, .otp_crc_fail, .otp_lock_factory, .accel_sample, .device_reset,
    .respond_enable, .downstream_switch_closed, .internal_fault_flag, .self_check_on_flag,
    .reserve_low_flag, .short_accel_data, .long_accel_data);
  sfr_dsi_master_model i_master (.hclk, .hresetn, .stuck_go, .stuck_len, .upstream_bus_low);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic hwait;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      close_out();
    end
  endtask : hwait
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    hwait();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwait();
    rd = hrdata;
  endtask : ahb
  task automatic cmd(input int b);
    ahb(1'b1, ADDR_COMMAND, 32'h1 << b);
    repeat (3) @(posedge hclk);
  endtask : cmd
  task automatic hold(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask : hold
  // Re-initialise after a fault reset: mark configured, close switch
  task automatic init_dev;
    cmd(CMD_INIT_DONE_BIT);
    cmd(CMD_SW_CLOSE_BIT);
  endtask : init_dev
  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, num_errors);
  endtask : done
  initial begin
    hold(20);
    check({hreadyout, hresp, device_reset, downstream_switch_closed}, 32'hA);
    check(hrdata, RDATA_RESET);
    @(posedge hclk);
    hresetn <= 1'b1;
    init_dev();
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check({rd[ST_CONFIG_BIT], rd[ST_RESPOND_BIT], rd[ST_SWITCH_BIT]}, 32'h7);
    done("reset");
    foreach (rows[i]) begin
      @(posedge hclk);
      {otp_crc_fail, otp_lock_factory, reserve_cap_low, accel_sample} <= rows[i][36:18];
      hold(2);
      check({internal_fault_flag, self_check_on_flag, reserve_low_flag},
        {rows[i].s, 1'b0, rows[i].u});
      check(short_accel_data, rows[i].sh);
      check(long_accel_data, rows[i].acc);
    end
    @(posedge hclk);
    {otp_crc_fail, otp_lock_factory, reserve_cap_low} <= 3'h0;
    done("table");
    cmd(CMD_ST_ENABLE_BIT);
    reserve_cap_low <= 1'b1;
    accel_sample    <= 16'h7777;
    hold(2);
    check({internal_fault_flag, self_check_on_flag, reserve_low_flag}, 32'h3);
    check({short_accel_data, long_accel_data}, 32'h7777_7777);
    @(posedge hclk);
    reserve_cap_low <= 1'b0;
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[ST_CONFIG_BIT], 32'h1);
    done("self check dip");
    cmd(CMD_ST_DISABLE_BIT);
    cmd(CMD_ST_DISABLE_BIT);
    cmd(CMD_ST_ENABLE_BIT);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check({rd[ST_LOCKOUT_BIT], self_check_on_flag}, 32'h2);
    done("lockout");
    ahb(1'b0, ADDR_RESET_COUNT, 32'h0);
    c0 = rd;
    stuck_len <= 16'(2 * FRM_N + FRM_N / 2);
    stuck_go  <= 1'b1;
    @(posedge hclk);
    stuck_go  <= 1'b0;
    hold(FRM_N + 10);
    check({respond_enable, downstream_switch_closed}, 32'h0);
    hold(FRM_N * 2);
    ahb(1'b0, ADDR_RESET_COUNT, 32'h0);
    check(rd - c0, 32'h2);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[ST_LOCKOUT_BIT], 32'h0);
    init_dev();
    done("frame timeout");
    ahb(1'b0, ADDR_RESET_COUNT, 32'h0);
    c0 = rd;
    reserve_cap_low <= 1'b1;
    hold(RES_N + 10);
    check({respond_enable, downstream_switch_closed}, 32'h0);
    hold(2 * RES_N + 15);
    @(posedge hclk) reserve_cap_low <= 1'b0;
    ahb(1'b0, ADDR_RESET_COUNT, 32'h0);
    check(rd - c0, 32'h3);
    init_dev();
    check(downstream_switch_closed, 32'h1);
    done("reserve low");
    c0 = rd;
    cap_test_fail <= 1'b1;
    hold(2 * CAP_N + 20);
    check(respond_enable, 32'h0);
    @(posedge hclk) cap_test_fail <= 1'b0;
    ahb(1'b0, ADDR_RESET_COUNT, 32'h0);
    check(rd - c0, 32'h3);
    init_dev();
    done("capacitor test");
    cmd(CMD_ST_DISABLE_BIT);
    cmd(CMD_ST_DISABLE_BIT);
    digital_regulator_low <= 1'b1;
    hold(10);
    check({device_reset, respond_enable}, 32'h2);
    @(posedge hclk) {digital_regulator_low, analog_regulator_low} <= 2'h1;
    hold(10);
    check(device_reset, 32'h1);
    @(posedge hclk) analog_regulator_low <= 1'b0;
    init_dev();
    cmd(CMD_ST_ENABLE_BIT);
    check(self_check_on_flag, 32'h1);
    cmd(CMD_CLEAR_BIT);
    check(self_check_on_flag, 32'h0);
    ahb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    done("regulator and bus");
    hresetn <= 1'b0;
    hold(2);
    check({device_reset, downstream_switch_closed, self_check_on_flag}, 32'h4);
    done("second reset");
    close_out();
  end
endmodule : tb_sfr_fault_response
